// ===== inc/smc_pkg.sv
package smc_pkg;

    // =====================================================================
    // sleep modes
    // =====================================================================
    localparam int MODE_W = 3;
    typedef enum logic [2:0] {
        SMC_IDLE        = 3'h0,
        SMC_ADC_NR      = 3'h1,
        SMC_POWER_DOWN  = 3'h2,
        SMC_POWER_SAVE  = 3'h3,
        SMC_STANDBY     = 3'h6,
        SMC_EXT_STANDBY = 3'h7
    } smc_mode_t;

    // =====================================================================
    // gated functions, one enable bit each
    // =====================================================================
    typedef struct packed {
        logic cpu;
        logic sram;
        logic timers;
        logic spi;
        logic irq;
        logic adc;
        logic async_tmr;
        logic main_osc;
        logic rc_osc;
    } smc_clk_en_t;

    typedef struct packed {
        logic wdt;
        logic sym_cnt;
        logic osc32k;
    } smc_deep_keep_t;

    // =====================================================================
    // controller states
    // =====================================================================
    typedef enum logic [2:0] {
        SMC_ST_ACTIVE = 3'h1,
        SMC_ST_SLEEP  = 3'h2,
        SMC_ST_DEEP   = 3'h4
    } smc_state_t;

    localparam smc_clk_en_t CLK_ALL_ON = 9'h1ff;
    localparam smc_clk_en_t CLK_ALL_OFF = 9'h000;
    localparam smc_deep_keep_t DEEP_KEEP_OFF = 3'h0;

endpackage : smc_pkg

// ===== rtl/smc_sleep_ctrl.sv
module smc_sleep_ctrl
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic sleep_req_i,
    input wire logic [2:0] sleep_mode_i,
    input wire logic deep_req_i,
    input wire smc_pkg::smc_deep_keep_t deep_keep_i,
    input wire logic wake_irq_i,
    output smc_pkg::smc_clk_en_t clk_en_o,
    output smc_pkg::smc_deep_keep_t deep_run_o,
    output logic deep_power_off_o,
    output logic sleeping_o
);

    // =====================================================================
    // mode decode
    // =====================================================================
    function automatic smc_pkg::smc_clk_en_t mode_enables(input logic [2:0] m);
        smc_pkg::smc_clk_en_t e;
        e = smc_pkg::CLK_ALL_OFF;
        case (m)
            smc_pkg::SMC_IDLE:
            begin
                e = smc_pkg::CLK_ALL_ON;
                e.cpu = 1'b0;
            end
            smc_pkg::SMC_ADC_NR:
            begin
                e.main_osc = 1'b1;
                e.rc_osc = 1'b1;
                e.adc = 1'b1;
                e.async_tmr = 1'b1;
                e.irq = 1'b1;
            end
            smc_pkg::SMC_POWER_DOWN: e = smc_pkg::CLK_ALL_OFF;
            smc_pkg::SMC_POWER_SAVE: e.async_tmr = 1'b1;
            smc_pkg::SMC_STANDBY: e.rc_osc = 1'b1;
            smc_pkg::SMC_EXT_STANDBY:
            begin
                e.rc_osc = 1'b1;
                e.async_tmr = 1'b1;
            end
            default: e = smc_pkg::CLK_ALL_ON;
        endcase
        return e;
    endfunction : mode_enables

    function automatic logic mode_valid(input logic [2:0] m);
        case (m)
            smc_pkg::SMC_IDLE, smc_pkg::SMC_ADC_NR, smc_pkg::SMC_POWER_DOWN,
            smc_pkg::SMC_POWER_SAVE, smc_pkg::SMC_STANDBY,
            smc_pkg::SMC_EXT_STANDBY: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : mode_valid

    // =====================================================================
    // wake input synchroniser
    // =====================================================================
    logic wake_meta;
    logic wake_sync;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end
        else
        begin
            wake_meta <= wake_irq_i;
            wake_sync <= wake_meta;
        end
    end

    // =====================================================================
    // state machine
    // =====================================================================
    smc_pkg::smc_state_t state;
    smc_pkg::smc_state_t next_state;
    logic [2:0] mode;

    always_comb
    begin
        next_state = state;
        case (state)
            smc_pkg::SMC_ST_ACTIVE:
            begin
                if (deep_req_i)
                    next_state = smc_pkg::SMC_ST_DEEP;
                else if (sleep_req_i && mode_valid(sleep_mode_i))
                    next_state = smc_pkg::SMC_ST_SLEEP;
            end
            smc_pkg::SMC_ST_SLEEP, smc_pkg::SMC_ST_DEEP:
            begin
                if (wake_sync)
                    next_state = smc_pkg::SMC_ST_ACTIVE;
            end
            default: next_state = smc_pkg::SMC_ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state <= smc_pkg::SMC_ST_ACTIVE;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            mode <= smc_pkg::SMC_IDLE;
        else if (state == smc_pkg::SMC_ST_ACTIVE && sleep_req_i)
            mode <= sleep_mode_i;
    end

    // =====================================================================
    // registered outputs
    // =====================================================================
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            clk_en_o <= smc_pkg::CLK_ALL_ON;
            deep_run_o <= smc_pkg::DEEP_KEEP_OFF;
            deep_power_off_o <= 1'b0;
            sleeping_o <= 1'b0;
        end
        else
        begin
            case (next_state)
                smc_pkg::SMC_ST_SLEEP:
                begin
                    clk_en_o <= mode_enables((state == smc_pkg::SMC_ST_ACTIVE)
                                             ? sleep_mode_i : mode);
                    deep_run_o <= smc_pkg::DEEP_KEEP_OFF;
                    deep_power_off_o <= 1'b0;
                    sleeping_o <= 1'b1;
                end
                smc_pkg::SMC_ST_DEEP:
                begin
                    clk_en_o <= smc_pkg::CLK_ALL_OFF;
                    if (state == smc_pkg::SMC_ST_ACTIVE)
                        deep_run_o <= deep_keep_i;
                    deep_power_off_o <= 1'b1;
                    sleeping_o <= 1'b1;
                end
                default:
                begin
                    clk_en_o <= smc_pkg::CLK_ALL_ON;
                    deep_run_o <= smc_pkg::DEEP_KEEP_OFF;
                    deep_power_off_o <= 1'b0;
                    sleeping_o <= 1'b0;
                end
            endcase
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    sequence s_wake_seen;
        wake_sync && sleeping_o;
    endsequence

    a_idle_cpu_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(sleeping_o) && !deep_power_off_o && mode == smc_pkg::SMC_IDLE
        |-> !clk_en_o.cpu && clk_en_o.sram && clk_en_o.timers && clk_en_o.spi && clk_en_o.irq)
        else $error("idle gating wrong");

    a_pdown_all_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sleeping_o && !deep_power_off_o && mode == smc_pkg::SMC_POWER_DOWN
        |-> clk_en_o == smc_pkg::CLK_ALL_OFF)
        else $error("power-down left a clock on");

    a_psave_async: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sleeping_o && !deep_power_off_o && mode == smc_pkg::SMC_POWER_SAVE
        |-> clk_en_o.async_tmr && !clk_en_o.cpu && !clk_en_o.main_osc)
        else $error("power-save gating wrong");

    a_adcnr_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sleeping_o && !deep_power_off_o && mode == smc_pkg::SMC_ADC_NR
        |-> clk_en_o.adc && clk_en_o.async_tmr && !clk_en_o.cpu && !clk_en_o.spi)
        else $error("adc noise reduction gating wrong");

    a_stby_rc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sleeping_o && !deep_power_off_o && mode == smc_pkg::SMC_STANDBY
        |-> clk_en_o.rc_osc && !clk_en_o.async_tmr && !clk_en_o.cpu)
        else $error("standby gating wrong");

    a_extstby_rc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sleeping_o && !deep_power_off_o && mode == smc_pkg::SMC_EXT_STANDBY
        |-> clk_en_o.rc_osc && clk_en_o.async_tmr && !clk_en_o.cpu)
        else $error("extended standby gating wrong");

    a_deep_keep: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state == smc_pkg::SMC_ST_ACTIVE && deep_req_i && !wake_sync
        |=> deep_power_off_o && deep_run_o == $past(deep_keep_i)
            && clk_en_o == smc_pkg::CLK_ALL_OFF)
        else $error("deep sleep entry wrong");

    a_wake_restore: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_wake_seen |=> !sleeping_o && clk_en_o == smc_pkg::CLK_ALL_ON && !deep_power_off_o)
        else $error("wake-up did not restore clocks");

    a_bad_mode_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state == smc_pkg::SMC_ST_ACTIVE && sleep_req_i && !deep_req_i
        && !mode_valid(sleep_mode_i) |=> !sleeping_o)
        else $error("undefined mode entered sleep");

endmodule : smc_sleep_ctrl

// ===== verification/tb_smc_sleep_ctrl.sv
`define CHK(got, exp) \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
        n_errors++; \
        $display("[ERR] %0t mismatch at line %0d", $time, `__LINE__); \
    end

module tb_smc_sleep_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================================
    // signals
    // =====================================================================
    typedef struct {logic [2:0] mode; logic [8:0] exp; logic [8:0] mask;} smc_tb_row_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sleep_req_i = 1'b0;
    logic [2:0] sleep_mode_i = 3'h0;
    logic deep_req_i = 1'b0;
    smc_pkg::smc_deep_keep_t deep_keep_i = 3'h0;
    logic wake_irq_i = 1'b0;
    smc_pkg::smc_clk_en_t clk_en_o;
    smc_pkg::smc_deep_keep_t deep_run_o;
    logic deep_power_off_o;
    logic sleeping_o;
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    // masks leave open the low four bits in idle and the sram bit in ADC noise reduction
    smc_tb_row_t rows [6] = '{
        '{3'h0, 9'h0f0, 9'h1f0},
        '{3'h1, 9'h01f, 9'h17f},
        '{3'h2, 9'h000, 9'h1ff},
        '{3'h3, 9'h004, 9'h1ff},
        '{3'h6, 9'h001, 9'h1ff},
        '{3'h7, 9'h005, 9'h1ff}};
    logic [2:0] keeps [2] = '{3'h5, 3'h2};

    smc_sleep_ctrl i_smc_sleep_ctrl (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .sleep_req_i(sleep_req_i),
        .sleep_mode_i(sleep_mode_i),
        .deep_req_i(deep_req_i),
        .deep_keep_i(deep_keep_i),
        .wake_irq_i(wake_irq_i),
        .clk_en_o(clk_en_o),
        .deep_run_o(deep_run_o),
        .deep_power_off_o(deep_power_off_o),
        .sleeping_o(sleeping_o)
    );

    always #5 clk_i = ~clk_i;

    // =====================================================================
    // tasks
    // =====================================================================
    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles >= 2000)
        begin
            n_errors++;
            end_sim();
        end
    end

    task automatic step();
        @(posedge clk_i);
        #1;
    endtask : step

    task automatic request(input logic [2:0] mode, input logic deep, input logic [2:0] keep);
        sleep_req_i = 1'b1;
        sleep_mode_i = mode;
        deep_req_i = deep;
        deep_keep_i = keep;
        step();
        sleep_req_i = 1'b0;
        deep_req_i = 1'b0;
    endtask : request

    task automatic wake();
        wake_irq_i = 1'b1;
        repeat (2) step();
        `CHK(sleeping_o, 1'b1)
        step();
        `CHK({sleeping_o, deep_power_off_o, deep_run_o, clk_en_o}, 14'h01ff)
        wake_irq_i = 1'b0;
        repeat (3) step();
    endtask : wake

    // =====================================================================
    // sequence
    // =====================================================================
    initial
    begin
        repeat (4) step();
        `CHK({sleeping_o, deep_power_off_o, deep_run_o, clk_en_o}, 14'h01ff)
        step();
        reset_n_i = 1'b1;
        step();
        foreach (rows[i])
        begin
            request(rows[i].mode, 1'b0, 3'h0);
            `CHK(clk_en_o & rows[i].mask, rows[i].exp)
            `CHK({sleeping_o, deep_power_off_o, deep_run_o}, 5'h10)
            wake();
        end
        // codes 4 and 5 are not modes
        for (int m = 4; m < 6; m++)
        begin
            request(m[2:0], 1'b0, 3'h0);
            `CHK({sleeping_o, clk_en_o}, 10'h1ff)
            step();
        end
        // deep request beats a sleep request in the same cycle
        foreach (keeps[i])
        begin
            request(3'h0, 1'b1, keeps[i]);
            `CHK({sleeping_o, deep_power_off_o, deep_run_o, clk_en_o}, {2'h3, keeps[i], 9'h0})
            deep_keep_i = ~keeps[i];
            step();
            `CHK(deep_run_o, keeps[i])
            wake();
        end
        // requests while asleep are ignored
        request(3'h0, 1'b0, 3'h0);
        step();
        request(3'h3, 1'b1, 3'h7);
        `CHK({sleeping_o, deep_power_off_o, deep_run_o, clk_en_o[8]}, 6'h20)
        wake();
        // back to back after wake, then a hardware reset ends power-down
        request(3'h2, 1'b0, 3'h0);
        `CHK({sleeping_o, clk_en_o}, 10'h200)
        step();
        `CHK({sleeping_o, clk_en_o}, 10'h200)
        reset_n_i = 1'b0;
        #2;
        `CHK({sleeping_o, deep_power_off_o, deep_run_o, clk_en_o}, 14'h01ff)
        step();
        reset_n_i = 1'b1;
        step();
        request(3'h7, 1'b0, 3'h0);
        `CHK(clk_en_o, 9'h005)
        wake();
        end_sim();
    end

endmodule : tb_smc_sleep_ctrl
